/* pkg/ast_pkg.sv */
package ast_pkg;
    // character format
    localparam int unsigned DATA_BITS_MAX   = 9;
    localparam int unsigned CHAR_W          = 8;
    // baud generator
    localparam int unsigned DIV_W           = 16;
    localparam logic [DIV_W-1:0] DIV_RESET  = 16'h0000;
    // control reset values
    localparam logic POL_INV_RESET          = 1'b0;
    localparam logic NINE_BIT_RESET         = 1'b0;
    // holding buffer depth
    localparam int unsigned BUF_DEPTH       = 2;
    // flag settle time after a buffer write, in instruction cycles
    localparam int unsigned FLAG_SETTLE_CYC = 2;
    // clock period in ns and instruction cycle in clocks
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned TCY_NS          = 5;
    localparam int unsigned TCY_CLKS        = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        AST_IDLE  = 2'b00,
        AST_START = 2'b01,
        AST_DATA  = 2'b10,
        AST_STOP  = 2'b11
    } ast_state_t;
endpackage

/* pkg/ast_stream_if.sv */
interface ast_stream_if #(parameter int unsigned W = 9);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

/* src/ast_skid_buffer.sv */
module ast_skid_buffer
    import ast_pkg::*;
#(
    parameter int unsigned W     = 9,
    parameter int unsigned DEPTH = BUF_DEPTH
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // synchronous flush
    input  wire logic flush,
    // stream ports
    ast_stream_if.sink   inp,
    ast_stream_if.source outp
);
    initial
    begin
        if (DEPTH != 2)
            $error("ast_skid_buffer supports DEPTH of 2 only");
    end

    typedef struct packed
    {
        logic [1:0][W-1:0] mem;
        logic [1:0]        count;
        logic              rdPtr;
        logic              wrPtr;
    } ast_buf_t;

    ast_buf_t st;
    ast_buf_t next_st;

    logic push;
    logic pop;

    assign inp.ready  = (st.count != 2'h2);
    assign outp.valid = (st.count != 2'h0);
    assign outp.data  = st.mem[st.rdPtr];
    assign push       = inp.valid && inp.ready;
    assign pop        = outp.valid && outp.ready;

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wrPtr] = inp.data;
            next_st.wrPtr         = ~st.wrPtr;
        end
        if (pop)
            next_st.rdPtr = ~st.rdPtr;
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
        if (flush)
        begin
            next_st.count = 2'h0;
            next_st.rdPtr = 1'b0;
            next_st.wrPtr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

/* src/ast_transmitter.sv */
// Summary of operation
// - transmitter runs only with enable set, clocked mode clear, port enabled
// - an enabled port drives the transmit pin only while transmit enable is also set, regardless of direction setting
// - a disabled transmitter releases the pin for general use
// - NRZ: idle and stop are mark, start is space, one is mark
// - one start bit, eight or nine data bits, one stop bit
// - each bit lasts one full bit period
// - data leaves least significant bit first
// - bit period from shared 8/16-bit divider on the system clock
// - no hardware parity; software puts it in the ninth bit
// - a write moves straight into an empty shift register
// - a waiting character loads within one instruction cycle after stop
// - the start bit begins right after the load
// - polarity invert inverts idle and data levels; resets to zero
// - buffer-empty flag set when enabled and nothing waits in the buffer
// - buffer-empty flag correct by the second instruction cycle after a write
// - buffer-empty flag is read-only and follows buffer state, gated by the transmitter running
// - interrupt request needs both flag and interrupt enable
// - shift-register-empty set while idle, clear from load until fully sent
// - nine-bit select sends a ninth bit taken from the ninth-bit input
// - ninth bit is captured with the low byte on the buffer write
// - the ninth bit is carried through unchanged
module ast_transmitter
    import ast_pkg::*;
#(
    parameter int unsigned DW = DIV_W
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // port control
    input  wire logic          transmit_enable_bit,
    input  wire logic          clocked_mode_select,
    input  wire logic          serial_port_enable,
    input  wire logic          nine_bit_tx_select,
    input  wire logic          ninth_tx_bit,
    input  wire logic          tx_polarity_invert,
    input  wire logic          tx_interrupt_enable,
    // baud generator control
    input  wire logic [7:0]    baud_divisor_high,
    input  wire logic [7:0]    baud_divisor_low,
    input  wire logic          baud_high_speed_select,
    input  wire logic          baud_wide_counter_select,
    // holding buffer write
    input  wire logic          txWrite,
    input  wire logic [7:0]    txData,
    output logic               txWriteReady,
    // status
    output logic               tx_buffer_empty_flag,
    output logic               shift_register_empty,
    output logic               txIrq,
    // pin
    output logic               tx_pin_out,
    output logic               tx_pin_oe
);
    initial
    begin
        if (DW != 16)
            $error("ast_transmitter needs a 16-bit divider");
    end

    localparam int unsigned FW = DATA_BITS_MAX;
    localparam logic [3:0] BITS8 = 4'h8;
    localparam logic [3:0] BITS9 = 4'h9;

    typedef struct packed
    {
        ast_state_t     state;
        logic [FW-1:0]  shift;
        logic [3:0]     bitsLeft;
        logic           nine;
        logic           inv;
        logic [DW+3:0]  baudCnt;
        logic           line;
        logic           bufEmpty;
        logic           srEmpty;
        logic           irq;
        logic           oe;
    } ast_tx_t;

    ast_tx_t st;
    ast_tx_t next_st;

    logic active;
    logic tick;
    logic loadNow;
    logic [DW+3:0] divEnd;

    ast_stream_if #(.W(FW)) inBus ();
    ast_stream_if #(.W(FW)) outBus ();

    // divisor plus one times the prescale, minus one; wide enough for a full 16-bit divisor
    function automatic logic [DW+3:0] baud_period(input logic [DW-1:0] div,
                                                   input logic hs, input logic wide);
        logic [DW+3:0] n;
        n = {4'h0, div} + 20'h00001;
        case ({wide, hs})
            2'b00:   baud_period = (n << 6) - 20'h00001;
            2'b01,
            2'b10:   baud_period = (n << 4) - 20'h00001;
            default: baud_period = (n << 2) - 20'h00001;
        endcase
    endfunction

    assign active = transmit_enable_bit && !clocked_mode_select && serial_port_enable;
    assign divEnd = baud_period(baud_wide_counter_select ? {baud_divisor_high, baud_divisor_low}
                                                         : {8'h00, baud_divisor_low},
                                baud_high_speed_select, baud_wide_counter_select);

    // 9-bit capture keeps the ninth bit paired with its byte
    assign inBus.valid   = txWrite && active;
    assign inBus.data    = {ninth_tx_bit, txData};
    assign txWriteReady  = inBus.ready;
    assign loadNow       = outBus.valid && (st.state == AST_IDLE) && active;
    assign outBus.ready  = loadNow;
    assign tick          = (st.baudCnt == divEnd);

    ast_skid_buffer #(.W(FW), .DEPTH(BUF_DEPTH)) u_buf
    (
        .clk    (clk),
        .arst_n (arst_n),
        .flush  (!active),
        .inp    (inBus),
        .outp   (outBus)
    );

    always_comb
    begin
        next_st = st;
        next_st.baudCnt = tick ? '0 : st.baudCnt + 20'h00001;
        case (st.state)
            AST_IDLE:
            begin
                next_st.line = 1'b1;
                if (loadNow)
                begin
                    // settings sampled per character
                    next_st.shift    = outBus.data;
                    next_st.nine     = nine_bit_tx_select;
                    next_st.inv      = tx_polarity_invert;
                    next_st.bitsLeft = nine_bit_tx_select ? BITS9 : BITS8;
                    next_st.state    = AST_START;
                    next_st.line     = 1'b0;
                    next_st.baudCnt  = '0;
                end
            end
            AST_START:
            begin
                if (tick)
                begin
                    next_st.state = AST_DATA;
                    next_st.line  = st.shift[0];
                    next_st.shift = st.shift >> 1;
                    next_st.bitsLeft = st.bitsLeft - 4'h1;
                end
            end
            AST_DATA:
            begin
                if (tick)
                begin
                    if (st.bitsLeft == 4'h0)
                    begin
                        next_st.state = AST_STOP;
                        next_st.line  = 1'b1;
                    end
                    else
                    begin
                        next_st.line  = st.shift[0];
                        next_st.shift = st.shift >> 1;
                        next_st.bitsLeft = st.bitsLeft - 4'h1;
                    end
                end
            end
            AST_STOP:
            begin
                if (tick)
                    next_st.state = AST_IDLE;
            end
            default:
            begin
                next_st.state = AST_IDLE;
            end
        endcase
        if (!active)
        begin
            next_st.state   = AST_IDLE;
            next_st.line    = 1'b1;
            next_st.baudCnt = '0;
            next_st.inv     = tx_polarity_invert;
        end
        // no parity generator: ninth bit is whatever software wrote
        next_st.srEmpty = (next_st.state == AST_IDLE);
        // flag derives from the buffer's next occupancy gated by active, changing on the same edge as the buffer, well inside the settle time
        // a load from a full buffer still leaves one character waiting
        next_st.bufEmpty = active && !inBus.valid
                           && (!outBus.valid || (loadNow && inBus.ready));
        next_st.irq = next_st.bufEmpty && tx_interrupt_enable;
        next_st.oe  = serial_port_enable;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st          <= '0;
            st.state    <= AST_IDLE;
            st.line     <= 1'b1;
            st.srEmpty  <= 1'b1;
            st.inv      <= POL_INV_RESET;
            st.nine     <= NINE_BIT_RESET;
        end
        else
            st <= next_st;
    end

    assign tx_buffer_empty_flag = st.bufEmpty;
    assign shift_register_empty = st.srEmpty;
    assign txIrq                = st.irq;
    assign tx_pin_out           = st.line ^ st.inv;
    assign tx_pin_oe            = st.oe && transmit_enable_bit;
endmodule

/* tb/ast_transmitter_asserts.sv */
module ast_transmitter_asserts
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic transmit_enable_bit,
    input wire logic clocked_mode_select,
    input wire logic serial_port_enable,
    input wire logic tx_polarity_invert,
    input wire logic tx_interrupt_enable,
    // write and status
    input wire logic txWrite,
    input wire logic txWriteReady,
    input wire logic tx_buffer_empty_flag,
    input wire logic shift_register_empty,
    input wire logic txIrq,
    // pin
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic act;
    assign act = transmit_enable_bit && !clocked_mode_select && serial_port_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_OE_ON: assert property (act[*2] |-> tx_pin_oe)
        else $error("pin not driven while enabled");
    AST_OE_OFF: assert property ((!serial_port_enable || !transmit_enable_bit)[*2] |-> !tx_pin_oe)
        else $error("pin driven while disabled");
    AST_IDLE: assert property ((shift_register_empty && $stable(tx_polarity_invert))[*3]
        |-> tx_pin_out != tx_polarity_invert)
        else $error("idle line not at mark");
    AST_START: assert property ((act && txWrite && txWriteReady && shift_register_empty) ##1 act[*2]
        |-> !shift_register_empty && tx_pin_out == tx_polarity_invert)
        else $error("start bit late after write");
    AST_SRE_HOLD: assert property ($fell(shift_register_empty)
        |-> (!shift_register_empty || !act)[*8])
        else $error("shift empty set mid frame");
    AST_BIT_HOLD: assert property (act && !shift_register_empty && $changed(tx_pin_out)
        |=> ($stable(tx_pin_out) || !act)[*3])
        else $error("bit shorter than period");
    AST_IRQ_OFF: assert property (!tx_interrupt_enable[*2] |-> !txIrq)
        else $error("irq without enable");
    AST_IRQ_ON: assert property ((tx_buffer_empty_flag && tx_interrupt_enable)[*2] |-> txIrq)
        else $error("irq missing");
    AST_FLAG_OFF: assert property (!act[*3] |-> !tx_buffer_empty_flag)
        else $error("flag set while disabled");
    AST_FLAG_ON: assert property ((act && shift_register_empty && !txWrite)[*3]
        |-> tx_buffer_empty_flag)
        else $error("flag clear while empty");

    cover property (act && !txWriteReady);
    cover property ($fell(serial_port_enable) && !shift_register_empty);
    cover property (txIrq);
endmodule

bind ast_transmitter ast_transmitter_asserts chk_u (.clk, .arst_n, .transmit_enable_bit,
    .clocked_mode_select, .serial_port_enable, .tx_polarity_invert, .tx_interrupt_enable,
    .txWrite, .txWriteReady, .tx_buffer_empty_flag, .shift_register_empty, .txIrq,
    .tx_pin_out, .tx_pin_oe);

/* tb/ast_line_receiver.sv */
module ast_line_receiver
#(
    parameter int P = 8
)
(
    input  wire logic clk,
    input  wire logic line,
    input  wire logic inv,
    input  wire logic nine,
    output logic [8:0] rxData,
    output int         rxCount,
    output int         frameErr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] w;
    initial
    begin
        rxCount = 0;
        frameErr = 0;
        rxData = '0;
    end
    always
    begin
        @(posedge clk);
        if ((line ^ inv) == 1'b0)
        begin
            repeat (P / 2) @(posedge clk);
            w = '0;
            for (int i = 0; i < (nine ? 9 : 8); i++)
            begin
                repeat (P) @(posedge clk);
                w[i] = line ^ inv;
            end
            repeat (P) @(posedge clk);
            if ((line ^ inv) !== 1'b1)
                frameErr++;
            rxData = w;
            rxCount++;
        end
    end
endmodule

/* tb/ast_transmitter_test.sv */
module ast_transmitter_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic n; logic b; logic v; logic [7:0] d; logic [8:0] e;} ast_row_t;
    logic clk = 1'b0, arst_n = 1'b0, transmit_enable_bit = 1'b0, clocked_mode_select = 1'b0;
    logic serial_port_enable = 1'b0, nine_bit_tx_select = 1'b0, ninth_tx_bit = 1'b0;
    logic tx_polarity_invert = 1'b0, tx_interrupt_enable = 1'b0, txWrite = 1'b0;
    logic [7:0] txData = 8'h00;
    logic txWriteReady, tx_buffer_empty_flag, shift_register_empty, txIrq, tx_pin_out, tx_pin_oe;
    logic [8:0] rxData;
    int rxCount, frameErr, err_count = 0, tests_run = 0, base;
    // released pin is biased toward mark
    wire line = tx_pin_oe ? tx_pin_out : !tx_polarity_invert;
    ast_row_t rows [4] = '{'{1'b0, 1'b0, 1'b0, 8'hA5, 9'h0A5}, '{1'b1, 1'b1, 1'b0, 8'h3C, 9'h13C},
        '{1'b1, 1'b0, 1'b1, 8'hFF, 9'h0FF}, '{1'b0, 1'b1, 1'b1, 8'h01, 9'h001}};

    always #2.5 clk = ~clk;

    // divisor 1, both speed selects: 8 clocks a bit
    ast_transmitter dut_u (.clk, .arst_n, .transmit_enable_bit, .clocked_mode_select,
        .serial_port_enable, .nine_bit_tx_select, .ninth_tx_bit, .tx_polarity_invert,
        .tx_interrupt_enable, .baud_divisor_high(8'h00), .baud_divisor_low(8'h01),
        .baud_high_speed_select(1'b1), .baud_wide_counter_select(1'b1), .txWrite, .txData,
        .txWriteReady, .tx_buffer_empty_flag, .shift_register_empty, .txIrq, .tx_pin_out,
        .tx_pin_oe);
    ast_line_receiver #(.P(8)) rx_u (.clk, .line, .inv(tx_polarity_invert),
        .nine(nine_bit_tx_select), .rxData, .rxCount, .frameErr);

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // last lowers the strobe, so back-to-back writes hold it up
    task automatic send(input logic [7:0] d, input logic last);
        txData = d;
        txWrite = 1'b1;
        cyc(1);
        if (last)
            txWrite = 1'b0;
    endtask
    task automatic waitRx(input int n);
        for (int i = 0; i < 2000 && rxCount < n; i++)
            cyc(1);
        if (rxCount < n)
        begin
            err_count++;
            $display("ERROR %0t: no frame", $time);
            give_verdict();
        end
    endtask
    // format is changed only while disabled so the line never glitches
    task automatic setup(input logic n, input logic b, input logic v);
        transmit_enable_bit = 1'b0;
        cyc(2);
        nine_bit_tx_select = n;
        ninth_tx_bit = b;
        tx_polarity_invert = v;
        cyc(2);
        transmit_enable_bit = 1'b1;
        cyc(3);
        chk(tx_buffer_empty_flag, 9'h001);
    endtask

    initial
    begin
        cyc(3);
        chk({tx_pin_oe, shift_register_empty, tx_buffer_empty_flag, txIrq}, 9'h004);
        arst_n = 1'b1;
        serial_port_enable = 1'b1;
        foreach (rows[i])
        begin
            setup(rows[i].n, rows[i].b, rows[i].v);
            base = rxCount;
            send(rows[i].d, 1'b1);
            waitRx(base + 1);
            chk(rxData, rows[i].e);
        end
        setup(1'b0, 1'b0, 1'b0);
        base = rxCount;
        send(8'h11, 1'b0);
        send(8'h22, 1'b0);
        send(8'h33, 1'b1);
        cyc(2);
        chk({tx_buffer_empty_flag, txWriteReady}, 9'h000);
        tx_interrupt_enable = 1'b1;
        cyc(2);
        chk(txIrq, 9'h000);
        for (int k = 1; k < 4; k++)
        begin
            waitRx(base + k);
            chk(rxData, 9'(8'h11 * k));
        end
        cyc(12);
        chk({tx_buffer_empty_flag, txIrq, shift_register_empty}, 9'h007);
        tx_interrupt_enable = 1'b0;
        cyc(2);
        chk({tx_buffer_empty_flag, txIrq}, 9'h002);
        send(8'h00, 1'b1);
        cyc(20);
        serial_port_enable = 1'b0;
        cyc(3);
        chk({tx_pin_oe, shift_register_empty}, 9'h001);
        serial_port_enable = 1'b1;
        cyc(3);
        chk({tx_pin_oe, tx_pin_out, shift_register_empty}, 9'h007);
        cyc(120);
        base = rxCount;
        clocked_mode_select = 1'b1;
        cyc(2);
        send(8'h5A, 1'b1);
        cyc(40);
        chk({shift_register_empty, 8'(rxCount - base)}, 9'h100);
        clocked_mode_select = 1'b0;
        cyc(4);
        chk(9'(frameErr), 9'h000);
        give_verdict();
    end
endmodule
